// file: rtl/etx_mac_tx.sv
// Ethernet MAC transmit path with receive activity detect and APB map
//
// Contract
// - A kick from software starts fetching frame bytes into the FIFO.
// - Start when FIFO fill reaches threshold or a whole frame is held.
// - Transmit only after a 96 bit idle gap and any backoff.
// - Prefix 56 preamble bits and SFD, append FCS after data.
// - With pad enabled, zero-pad short data to 60 bytes before FCS.
// - Symbol modes send JK in place of the first preamble byte.
// - Symbol modes send TR right after the last FCS byte.
// - Carrier during gap phase one restarts that phase from zero.
// - Gap phase two ignores carrier and then transmits anyway.
// - Collision pin in serial/MII; receive activity in symbol modes.
// - On collision stop data, send jam, then back off.
// - Collision in preamble: finish preamble first, then jam.
// - Back off r slots of 512 bits, r from 0 to 2^min(n,10).
// - First backoff after a collision is at least one slot.
// - Sixteen collided attempts set excessive collision and finish.
// - Underflow flags both statuses and ends frame with bad CRC.
// - Jabber timer cuts long frames; short or long limit.
// - Collision after 64 bytes cuts off and flags late collision.
// - Fetch memory error ends transmission with error flag.
// - Write descriptor status each frame; raise complete if enabled.
// - Flag receive start from mode-specific line activity.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "etx_defs.svh"

module etx_mac_tx #(
  parameter int FIFO_AW = 11,
  parameter int JAB_SHORT_NIBS = `ETX_JAB_SHORT_BITS / `ETX_BITS_PER_NIB,
  parameter int JAB_LONG_NIBS = `ETX_JAB_LONG_BITS / `ETX_BITS_PER_NIB
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  input wire logic mem_last,
  input wire logic mem_err,
  output logic mem_ready,
  input wire etx_pkg::etx_line_in_t line_i,
  output etx_pkg::etx_line_out_t line_o,
  output logic rx_start,
  output logic normal_irq
);
  import etx_pkg::*;

  localparam int NB = `ETX_BITS_PER_NIB;
  localparam logic [7:0] GAP_PHASE_ONE_N = 8'(`ETX_GAP_PHASE_ONE_BITS / NB);
  localparam logic [7:0] GAP_PHASE_TWO_N = 8'(`ETX_GAP_PHASE_TWO_BITS / NB);
  localparam logic [7:0] PRE_N = 8'(`ETX_PRE_BITS / NB);
  localparam logic [7:0] JAM_N = 8'(`ETX_JAM_BITS / NB);
  localparam logic [7:0] SLOT_N = 8'(`ETX_SLOT_BITS / NB);
  localparam int DEPTH = 1 << FIFO_AW;

  // ==================================================================
  // Pin synchronisers
  etx_line_in_t s1_q, s2_q;
  logic lk_q;
  logic lk_rise;

  // Edge finder reads only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      lk_q <= 1'b0;
    end else begin
      s1_q <= line_i;
      s2_q <= s1_q;
      lk_q <= s2_q.link_clk;
    end
  end

  // one step per rising link clock edge
  assign lk_rise = s2_q.link_clk & ~lk_q;

  // ==================================================================
  // Register file over APB
  logic [31:0] ctrl_q, gst_q, ien_q, dctl_q, dst_q, prdata_q;
  logic wr_w, hit_w, go_w;
  logic sel_ctrl, sel_gst, sel_ien, sel_dctl, sel_dst;
  logic [31:0] rd_mux;
  etx_mode_t mode_w;
  logic sym_w;
  logic [31:0] gst_rd;
  logic pend_q;
  etx_state_t st_q, st_d;

  assign sel_ctrl = paddr == `ETX_OFF_CTRL;
  assign sel_gst = paddr == `ETX_OFF_GSTAT;
  assign sel_ien = paddr == `ETX_OFF_IEN;
  assign sel_dctl = paddr == `ETX_OFF_DCTL;
  assign sel_dst = paddr == `ETX_OFF_DSTAT;
  assign hit_w = sel_ctrl | sel_gst | sel_ien | sel_dctl | sel_dst;
  assign pready = psel & penable;
  assign pslverr = pready & ~hit_w;
  assign wr_w = pready & pwrite & hit_w;
  // kick ignored while a frame is still owned
  assign go_w = wr_w & sel_ctrl & pwdata[`ETX_CTRL_GO] & ~pend_q;
  assign mode_w = etx_mode_t'(ctrl_q[`ETX_CTRL_MODE +: 2]);
  assign sym_w = mode_w == ETX_SYM;

  // Read view: live receive activity and state folded into status
  logic rx_q;
  always_comb begin
    gst_rd = gst_q;
    gst_rd[`ETX_GST_RXB] = rx_q;
    gst_rd[`ETX_GST_STATE +: 4] = 4'(st_q);
  end
  assign rd_mux = sel_ctrl ? ctrl_q :
                  sel_gst ? gst_rd :
                  sel_ien ? ien_q :
                  sel_dctl ? dctl_q :
                  sel_dst ? dst_q : 32'h0000_0000;

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) prdata_q <= '0;
    else if (psel & ~penable) prdata_q <= rd_mux;
  end
  assign prdata = prdata_q;

  // Plain control registers; the kick bit never stores
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= `ETX_CTRL_RST;
      ien_q <= '0;
      dctl_q <= '0;
    end else if (wr_w) begin
      if (sel_ctrl) ctrl_q <= {pwdata[31:1], 1'b0};
      if (sel_ien) ien_q <= pwdata;
      if (sel_dctl) dctl_q <= pwdata;
    end
  end

  // ==================================================================
  // Transmit FIFO, one frame kept whole for retries
  logic [7:0] mem_q [DEPTH];
  logic [FIFO_AW:0] wr_q, rd_q, rd_d, base_q, fill_w;
  logic fetch_q, frame_in_q;
  logic full_w, acc_w, err_acc, avail_w, at_end, start_ok;
  logic [7:0] cur_w;
  logic fin;

  assign fill_w = wr_q - base_q;
  assign full_w = fill_w[FIFO_AW];
  assign mem_ready = fetch_q & ~full_w;
  assign acc_w = mem_valid & mem_ready & ~mem_err;
  assign err_acc = mem_valid & mem_ready & mem_err;
  assign avail_w = rd_q != wr_q;
  assign at_end = frame_in_q & ~avail_w;
  assign cur_w = mem_q[rd_q[FIFO_AW-1:0]];
  // threshold or complete frame, whichever first
  assign start_ok = frame_in_q |
    (fill_w >= (FIFO_AW+1)'(ctrl_q[`ETX_CTRL_THR +: 8]));

  // Byte store has no reset; pointers guard its contents
  always_ff @(posedge clk_sys) begin
    if (acc_w) mem_q[wr_q[FIFO_AW-1:0]] <= mem_data;
  end

  // Fetch side pointers and flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      base_q <= '0;
      fetch_q <= 1'b0;
      frame_in_q <= 1'b0;
    end else if (go_w) begin
      wr_q <= '0;
      base_q <= '0;
      fetch_q <= 1'b1;
      frame_in_q <= 1'b0;
    end else begin
      if (acc_w) wr_q <= wr_q + 1'b1;
      if ((acc_w & mem_last) | err_acc | fin) fetch_q <= 1'b0;
      if (acc_w & mem_last) frame_in_q <= 1'b1;
    end
  end

  // ==================================================================
  // Collision sense, backoff draw and jabber
  logic col_w;
  logic [15:0] lf_q, jab_q;
  logic [4:0] att_q, att_d, n_w;
  logic [3:0] k_w;
  logic [10:0] pow_w, r_raw, r_cap, r_w, slot_q, slot_d;
  logic jab_hit;
  etx_line_out_t out_q, out_d;

  // symbol modes: own receive input while sending
  assign col_w = sym_w ? s2_q.rx_active : s2_q.col;
  // k = min(n, 10), r capped at 2^k
  assign n_w = att_q + 5'h01;
  assign k_w = (n_w > 5'(`ETX_BO_LIMIT)) ? 4'(`ETX_BO_LIMIT) : 4'(n_w);
  assign pow_w = 11'h001 << k_w;
  assign r_raw = lf_q[10:0] & (pow_w | (pow_w - 11'h001));
  assign r_cap = (r_raw > pow_w) ? pow_w : r_raw;
  // first backoff never under one slot
  assign r_w = (n_w == 5'h01 && r_cap == '0) ? 11'h001 : r_cap;
  assign jab_hit = jab_q >= (ctrl_q[`ETX_CTRL_JABL] ?
    16'(JAB_LONG_NIBS) : 16'(JAB_SHORT_NIBS));

  // Free running draw source and jabber count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lf_q <= `ETX_LFSR_RST;
      jab_q <= '0;
    end else begin
      lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
      if (!out_q.en) jab_q <= '0;
      else if (lk_rise) jab_q <= jab_q + 16'h0001;
    end
  end

  // ==================================================================
  // Transmit sequencer
  logic [7:0] cnt_q, cnt_d;
  logic [10:0] byt_q, byt_d;
  logic [31:0] crc_q, crc_d, fcs_w;
  logic [3:0] nib_w, fcs_nib;
  logic half_q, half_d, padb_q, padb_d, bad_q, bad_d, colp_q, colp_d;
  logic uf_q, uf_d, lc_q, lc_d, ec_q, ec_d, jt_q, jt_d, me_q, me_d;
  logic pad_w;

  // Nibble-serial CRC, low bit first
  function automatic logic [31:0] crc_nib(input logic [31:0] c,
                                          input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      if (r[0] ^ d[i]) r = (r >> 1) ^ `ETX_CRC_POLY;
      else r = r >> 1;
    end
    return r;
  endfunction

  assign nib_w = padb_q ? 4'h0 : (half_q ? cur_w[7:4] : cur_w[3:0]);
  assign fcs_w = bad_q ? crc_q : ~crc_q;
  assign fcs_nib = 4'(fcs_w >> {cnt_q[2:0], 2'b00});
  // pad only when the control word asks
  assign pad_w = dctl_q[`ETX_DCTL_PAD] &
                 (byt_q < 11'(`ETX_MIN_BYTES));

  // Next state and line nibble
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    byt_d = byt_q;
    crc_d = crc_q;
    half_d = half_q;
    padb_d = padb_q;
    bad_d = bad_q;
    colp_d = colp_q;
    att_d = att_q;
    slot_d = slot_q;
    rd_d = rd_q;
    out_d = out_q;
    uf_d = uf_q;
    lc_d = lc_q;
    ec_d = ec_q;
    jt_d = jt_q;
    me_d = me_q;
    fin = 1'b0;
    unique case (st_q)
      ETX_IDLE: begin
        if (go_w) begin
          {uf_d, lc_d, ec_d, jt_d, me_d} = '0;
          att_d = '0;
          rd_d = '0;
        end else if (pend_q && start_ok) begin
          st_d = ETX_GAP_PHASE_ONE;
          cnt_d = '0;
        end
      end
      ETX_GAP_PHASE_ONE: if (lk_rise) begin
        if (s2_q.crs) cnt_d = '0;
        else if (cnt_q == GAP_PHASE_ONE_N - 8'h01) begin
          st_d = ETX_GAP_PHASE_TWO;
          cnt_d = '0;
        end else cnt_d = cnt_q + 8'h01;
      end
      ETX_GAP_PHASE_TWO: if (lk_rise) begin
        if (cnt_q == GAP_PHASE_TWO_N - 8'h01) begin
          st_d = ETX_PRE;
          cnt_d = '0;
          colp_d = 1'b0;
        end else cnt_d = cnt_q + 8'h01;
      end
      ETX_PRE: if (lk_rise) begin
        out_d.en = 1'b1;
        out_d.data = (cnt_q == PRE_N - 8'h01) ? `ETX_NIB_SFD :
                     `ETX_NIB_PRE;
        // JK takes the first preamble byte
        out_d.sym = (sym_w && cnt_q < 8'h02) ? `ETX_SYM_JK :
                    `ETX_SYM_DATA;
        if (sym_w && cnt_q < 8'h02) out_d.data = 4'(cnt_q);
        if (out_q.en && col_w) colp_d = 1'b1;
        if (cnt_q == PRE_N - 8'h01) begin
          st_d = (colp_d) ? ETX_JAM : ETX_DATA;
          cnt_d = '0;
          byt_d = '0;
          half_d = 1'b0;
          padb_d = 1'b0;
          bad_d = 1'b0;
          crc_d = `ETX_CRC_INIT;
        end else cnt_d = cnt_q + 8'h01;
      end
      ETX_DATA, ETX_FCS: if (lk_rise) begin
        out_d.sym = `ETX_SYM_DATA;
        if (col_w) begin
          out_d.data = `ETX_NIB_JAM;
          st_d = ETX_JAM;
          cnt_d = 8'h01;
        end else if (st_q == ETX_FCS) begin
          if (cnt_q == 8'h08) begin
            out_d.en = sym_w;
            out_d.sym = sym_w ? `ETX_SYM_TR : `ETX_SYM_DATA;
            out_d.data = 4'h0;
            st_d = sym_w ? ETX_TR : ETX_DONE;
          end else begin
            out_d.data = fcs_nib;
            cnt_d = cnt_q + 8'h01;
          end
        end else if (half_q) begin
          out_d.data = nib_w;
          crc_d = crc_nib(crc_q, nib_w);
          half_d = 1'b0;
          padb_d = 1'b0;
          if (!padb_q) rd_d = rd_q + 1'b1;
          byt_d = byt_q + 11'h001;
        end else if (avail_w) begin
          out_d.data = nib_w;
          crc_d = crc_nib(crc_q, nib_w);
          half_d = 1'b1;
        end else if (at_end && pad_w) begin
          // zero byte counted into the CRC
          out_d.data = 4'h0;
          crc_d = crc_nib(crc_q, 4'h0);
          half_d = 1'b1;
          padb_d = 1'b1;
        end else if (at_end) begin
          out_d.data = fcs_nib;
          st_d = ETX_FCS;
          cnt_d = 8'h01;
        end else begin
          // starved: flag and send raw CRC
          uf_d = 1'b1;
          bad_d = 1'b1;
          out_d.data = crc_q[3:0];
          st_d = ETX_FCS;
          cnt_d = 8'h01;
        end
      end
      ETX_TR: if (lk_rise) begin
        // T then R; the end pair never shows with the enable low
        if (out_q.data == 4'h0) out_d.data = 4'h1;
        else begin
          out_d = '0;
          st_d = ETX_DONE;
        end
      end
      ETX_JAM: if (lk_rise) begin
        if (cnt_q != JAM_N) begin
          out_d.data = `ETX_NIB_JAM;
          out_d.sym = `ETX_SYM_DATA;
          cnt_d = cnt_q + 8'h01;
        end else begin
          out_d.en = 1'b0;
          if (byt_q >= 11'(`ETX_LATE_BYTES)) begin
            lc_d = 1'b1;
            st_d = ETX_DONE;
          end else if (att_q == 5'(`ETX_ATTEMPTS - 1)) begin
            ec_d = 1'b1;
            st_d = ETX_DONE;
          end else begin
            att_d = n_w;
            slot_d = r_w;
            cnt_d = '0;
            rd_d = base_q;
            st_d = ETX_BACKOFF;
          end
        end
      end
      ETX_BACKOFF: begin
        if (slot_q == '0) begin
          st_d = ETX_GAP_PHASE_ONE;
          cnt_d = '0;
        end else if (lk_rise) begin
          if (cnt_q == SLOT_N - 8'h01) begin
            cnt_d = '0;
            slot_d = slot_q - 11'h001;
          end else cnt_d = cnt_q + 8'h01;
        end
      end
      ETX_DONE: begin
        fin = 1'b1;
        st_d = ETX_IDLE;
        out_d = '0;
      end
    endcase
    if (out_q.en && jab_hit) begin
      jt_d = 1'b1;
      out_d = '0;
      st_d = ETX_DONE;
    end
    if (err_acc) begin
      me_d = 1'b1;
      out_d = '0;
      st_d = ETX_DONE;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ETX_IDLE;
      {cnt_q, byt_q, crc_q, rd_q, att_q, slot_q} <= '0;
      {half_q, padb_q, bad_q, colp_q} <= '0;
      {uf_q, lc_q, ec_q, jt_q, me_q} <= '0;
      out_q <= '0;
    end else begin
      st_q <= st_d;
      {cnt_q, byt_q, crc_q, rd_q, att_q, slot_q} <=
        {cnt_d, byt_d, crc_d, rd_d, att_d, slot_d};
      {half_q, padb_q, bad_q, colp_q} <= {half_d, padb_d, bad_d, colp_d};
      {uf_q, lc_q, ec_q, jt_q, me_q} <= {uf_d, lc_d, ec_d, jt_d, me_d};
      out_q <= out_d;
    end
  end
  assign line_o = out_q;

  // ==================================================================
  // Completion status; hardware set wins over software clear
  logic [31:0] w1c_w, set_w;
  assign w1c_w = (wr_w & sel_gst) ? pwdata : 32'h0000_0000;
  always_comb begin
    set_w = '0;
    set_w[`ETX_GST_TXC] = fin;
    set_w[`ETX_GST_UF] = uf_d & ~uf_q;
    set_w[`ETX_GST_ME] = err_acc;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gst_q <= '0;
      dst_q <= '0;
      pend_q <= 1'b0;
    end else begin
      gst_q <= (gst_q & ~w1c_w) | set_w;
      if (go_w) begin
        pend_q <= 1'b1;
        dst_q <= 32'h0000_0000 | (32'h1 << `ETX_DST_OWN);
      end else if (fin) begin
        pend_q <= 1'b0;
        dst_q <= '0;
        dst_q[`ETX_DST_UF] <= uf_q;
        dst_q[`ETX_DST_CC +: 4] <= att_q[3:0];
        dst_q[`ETX_DST_EC] <= ec_q;
        dst_q[`ETX_DST_LC] <= lc_q;
        dst_q[`ETX_DST_JT] <= jt_q;
      end
    end
  end
  assign normal_irq = gst_q[`ETX_GST_TXC] & ien_q[`ETX_IEN_NIS];

  // ==================================================================
  // Receive activity detect
  logic rx_act_w, rx_start_q;
  // mode picks which pins mean activity
  assign rx_act_w = ctrl_q[`ETX_CTRL_RXEN] &
    ((mode_w == ETX_SRL) ? s2_q.srl_rxen :
     (mode_w == ETX_MII) ? (s2_q.media_rx_valid_in & s2_q.crs) :
     s2_q.rx_active);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_q <= 1'b0;
      rx_start_q <= 1'b0;
    end else begin
      rx_q <= rx_act_w;
      rx_start_q <= rx_act_w & ~rx_q;
    end
  end
  assign rx_start = rx_start_q;

endmodule

// file: rtl/etx_defs.svh
// Register map, field positions, reset values and timing figures
`ifndef ETX_DEFS_SVH
`define ETX_DEFS_SVH

// ====================================================================
// Register byte offsets
`define ETX_OFF_CTRL 8'h00
`define ETX_OFF_GSTAT 8'h04
`define ETX_OFF_IEN 8'h08
`define ETX_OFF_DCTL 8'h0C
`define ETX_OFF_DSTAT 8'h10

// ====================================================================
// Field positions
`define ETX_CTRL_GO 0
`define ETX_CTRL_RXEN 1
`define ETX_CTRL_MODE 2
`define ETX_CTRL_JABL 4
`define ETX_CTRL_THR 8
`define ETX_GST_TXC 0
`define ETX_GST_UF 5
`define ETX_GST_ME 13
`define ETX_GST_RXB 16
`define ETX_GST_STATE 24
`define ETX_IEN_NIS 16
`define ETX_DCTL_PAD 23
`define ETX_DST_UF 1
`define ETX_DST_CC 3
`define ETX_DST_EC 8
`define ETX_DST_LC 9
`define ETX_DST_JT 14
`define ETX_DST_OWN 31

// ====================================================================
// Reset values and CRC polynomial
`define ETX_CTRL_RST 32'h0000_4000
`define ETX_LFSR_RST 16'hACE1
`define ETX_CRC_INIT 32'hFFFF_FFFF
`define ETX_CRC_POLY 32'hEDB8_8320

// ====================================================================
// Line timing, in bit times, and frame figures
`define ETX_BITS_PER_NIB 4
`define ETX_GAP_PHASE_ONE_BITS 60
`define ETX_GAP_PHASE_TWO_BITS 36
`define ETX_PRE_BITS 64
`define ETX_JAM_BITS 32
`define ETX_SLOT_BITS 512
`define ETX_JAB_SHORT_BITS 16000
`define ETX_JAB_LONG_BITS 26000
`define ETX_ATTEMPTS 16
`define ETX_BO_LIMIT 10
`define ETX_MIN_BYTES 60
`define ETX_LATE_BYTES 64
`define ETX_NIB_PRE 4'h5
`define ETX_NIB_SFD 4'hD
`define ETX_NIB_JAM 4'hA
`define ETX_SYM_DATA 2'h0
`define ETX_SYM_JK 2'h1
`define ETX_SYM_TR 2'h2

`endif

// file: rtl/etx_pkg.sv
// Types shared by the transmit path and its users
package etx_pkg;

  // ==================================================================
  // Transmit sequencer states
  typedef enum {
    ETX_IDLE, ETX_GAP_PHASE_ONE, ETX_GAP_PHASE_TWO, ETX_PRE, ETX_DATA,
    ETX_FCS, ETX_TR, ETX_JAM, ETX_BACKOFF, ETX_DONE
  } etx_state_t;

  // Port flavour
  typedef enum logic [1:0] {ETX_SRL, ETX_MII, ETX_SYM} etx_mode_t;

  // Pins arriving from the transceiver, asynchronous
  typedef struct packed {
    logic link_clk;
    logic srl_rxen;
    logic media_rx_valid_in;
    logic crs;
    logic col;
    logic rx_active;
  } etx_line_in_t;

  // Pins going to the transceiver
  typedef struct packed {
    logic en;
    logic [1:0] sym;
    logic [3:0] data;
  } etx_line_out_t;

endpackage

// file: testbench/etx_sva.sv
// Port-level assertions for the transmit path
`timescale 1ns/100ps
module etx_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_valid,
  input wire logic mem_last,
  input wire logic mem_err,
  input wire logic mem_ready,
  input wire etx_pkg::etx_line_out_t line_o,
  input wire logic rx_start
);
  import etx_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==================================================================
  // Named steps of a bus access and of a frame start
  sequence acc_s;
    psel && penable;
  endsequence
  sequence pre_s;
    line_o.sym == 2'h1 || (line_o.sym == 2'h0 && line_o.data == 4'h5);
  endsequence
  // Zero wait states, errors above offset 0x10, no error on the control word
  zero_wait_a: assert property (acc_s |-> pready)
    else $error("access without ready");
  unmapped_err_a: assert property (acc_s and paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_s and paddr == 8'h00 |-> !pslverr)
    else $error("control access refused");
  // Fetch closes after the last byte or a host error
  fetch_stop_a: assert property (
    mem_valid && mem_ready && (mem_last || mem_err) |=> !mem_ready)
    else $error("fetch still open");
  rx_pulse_a: assert property (rx_start |=> !rx_start)
    else $error("receive start longer than a pulse");
  // Frames open with preamble or the start pair
  pre_start_a: assert property ($rose(line_o.en) |-> pre_s)
    else $error("frame does not open with preamble");
  // A burst lasts at least about 96 bit times: 24 steps of 12 clocks in this bench
  min_burst_a: assert property ($rose(line_o.en) |-> ##280 line_o.en)
    else $error("fragment too short");
  tr_in_frame_a: assert property (line_o.sym == 2'h2 |-> line_o.en)
    else $error("end pair outside a frame");
endmodule

bind etx_mac_tx etx_sva chk_u (
  .clk_sys(clk_sys),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .mem_valid(mem_valid),
  .mem_last(mem_last),
  .mem_err(mem_err),
  .mem_ready(mem_ready),
  .line_o(line_o),
  .rx_start(rx_start)
);

// file: testbench/etx_phy_model.sv
// Line transceiver model: nibble clock, carrier, collision
`timescale 1ns/100ps
module etx_phy_model (
  input wire logic col_req,
  input wire logic act_req,
  input wire etx_pkg::etx_line_out_t tx_i,
  output etx_pkg::etx_line_in_t line_i
);
  import etx_pkg::*;
  logic lclk = 1'b0;
  // Line clock runs free, as a transceiver clock does
  initial forever #24 lclk = ~lclk;
  // collision only against our own burst
  assign line_i.col = col_req & tx_i.en;
  assign line_i.rx_active = act_req | (col_req & tx_i.en);
  assign line_i.srl_rxen = act_req;
  assign line_i.media_rx_valid_in = act_req;
  assign line_i.crs = act_req;
  assign line_i.link_clk = lclk;
endmodule

// file: testbench/ethernet_mac_transmit_path_tb_top.sv
// Self-checking bench for the transmit path
`timescale 1ns/100ps
module ethernet_mac_transmit_path_tb_top;
  import etx_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, mem_valid = 1'b0, mem_last = 1'b0;
  logic mem_err = 1'b0, col_req = 1'b0, act_req = 1'b0, err;
  logic [7:0] paddr = 8'h00, mem_data = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  logic pready, pslverr, mem_ready, rx_start, normal_irq, seen;
  etx_line_in_t line_i;
  etx_line_out_t line_o;
  logic [5:0] expq[$], gotq[$];
  logic [7:0] fr[$];
  integer seed = 32'h7645_1589;
  int mismatches = 0, compares = 0, t;
  etx_mac_tx dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_valid(mem_valid), .mem_data(mem_data), .mem_last(mem_last),
    .mem_err(mem_err), .mem_ready(mem_ready), .line_i(line_i),
    .line_o(line_o), .rx_start(rx_start), .normal_irq(normal_irq));
  etx_phy_model phy_u (.col_req(col_req), .act_req(act_req),
    .tx_i(line_o), .line_i(line_i));
  // ==================================================================
  // Clock, capture, watchdog
  initial forever #2 clk_sys = ~clk_sys;
  // Mid-nibble sampling avoids the sync delay
  always @(negedge line_i.link_clk)
    if (line_o.en) gotq.push_back({line_o.sym, line_o.data});
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  // ==================================================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Expected nibbles: preamble, bytes low first, pad, inverted CRC
  function void build(input int n, input bit sym);
    logic [31:0] c;
    logic [7:0] b;
    c = 32'hFFFF_FFFF;
    expq = {};
    for (int i = 0; i < 16; i++) expq.push_back(i == 15 ? 6'h0D : 6'h05);
    if (sym) expq[0] = 6'h10;
    if (sym) expq[1] = 6'h11;
    for (int i = 0; i < (n < 60 ? 60 : n); i++) begin
      b = i < n ? fr[i] : 8'h00;
      expq.push_back({2'h0, b[3:0]});
      expq.push_back({2'h0, b[7:4]});
      for (int j = 0; j < 8; j++)
        c = (c >> 1) ^ ((c[0] ^ b[j]) ? 32'hEDB8_8320 : 32'h0000_0000);
    end
    c = ~c;
    for (int i = 0; i < 8; i++) expq.push_back({2'h0, c[4*i +: 4]});
    if (sym) expq.push_back(6'h20);
    if (sym) expq.push_back(6'h21);
  endfunction
  task frame(input int n, input logic [31:0] ctl, input bit sym, bit co);
    logic [31:0] v;
    logic r;
    fr = {};
    for (int i = 0; i < n; i++) begin
      v = $random(seed);
      fr.push_back(v[7:0]);
    end
    build(n, sym);
    for (int i = 0; i < (co ? 8 : 0); i++) expq.push_front(6'h0A);
    // First attempt: preamble and SFD, then jam, ahead of the retry
    for (int i = 0; i < (co ? 16 : 0); i++)
      expq.push_front(i == 0 ? 6'h0D : 6'h05);
    gotq = {};
    col_req <= co;
    apb(1'b1, 8'h00, ctl | 32'h0000_4001);
    for (int i = 0; i < n; ) begin
      mem_valid <= 1'b1;
      mem_data <= fr[i];
      mem_last <= (i == n - 1);
      @(negedge clk_sys);
      r = mem_ready;
      @(posedge clk_sys);
      if (r) i++;
    end
    mem_valid <= 1'b0;
    mem_last <= 1'b0;
    // Collision held until the jam burst is out
    for (t = 0; co && gotq.size() < 24 && t < 20000; t++) @(posedge clk_sys);
    col_req <= 1'b0;
    // A wait that runs out is a failure of its own
    if (co && gotq.size() < 24) mismatches++;
    t = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0000_0000);
      t++;
    end while (rdv[0] !== 1'b1 && t < 5000);
    if (rdv[0] !== 1'b1) mismatches++;
    chk(32'(gotq.size()), 32'(expq.size()));
    foreach (expq[i]) chk(32'(gotq[i]), 32'(expq[i]));
    chk(32'(normal_irq), 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rdv & 32'h8000_437A, co ? 32'h0000_0008 : 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0001);
    chk(32'(normal_irq), 32'h0000_0000);
  endtask
  task stop_test();
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rdv, 32'h0000_4000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 8'h0C, 32'h0080_0000);
    apb(1'b1, 8'h08, 32'h0001_0000);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h00, 32'h0000_4002 | (32'(m) << 2));
      act_req <= 1'b1;
      seen = 1'b0;
      repeat (20) @(posedge clk_sys) seen |= rx_start;
      act_req <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk({31'h0, seen}, 32'h0000_0001);
    end
    frame(20, 32'h0000_0004, 1'b0, 1'b0);
    frame(20, 32'h0000_0008, 1'b1, 1'b0);
    frame(70, 32'h0000_0004, 1'b0, 1'b1);
    stop_test();
  end
endmodule
